// File: core/cdrtoc_core.sv
/*
  Write-side control register bank of a clock and data recovery receiver:
  output buffer gating, output format, holdover, limited rate, error
  measurement start, length and result byte select, pattern generator mode.
  Assumes the serial management port delivers one-cycle write strobes with
  address and data on clk_sys, and the error count is on clk_sys too.
*/
`timescale 1ns/1ps
`default_nettype none
module cdrtoc_core (
  // Clock and reset
  input  wire  logic        clk_sys,
  input  wire  logic        resetn,
  // Register write port
  input  wire  logic        reg_wr_stb,
  input  wire  logic [7:0]  reg_addr,
  input  wire  logic [7:0]  reg_wr_data,
  // Error measurement result
  input  wire  logic [39:0] error_count,
  // Output buffers and datapath
  output logic              data_buf_en,
  output logic              clock_buf_en,
  output logic              cdr_bypass,
  output logic              odc_select,
  output logic              ddr_mode,
  output logic              pattern_path_en,
  // Error rate monitor
  output logic              error_mon_en,
  output logic              error_mon_standby,
  output logic              measure_start,
  output logic [5:0]        measure_len_log2,
  output logic [7:0]        error_byte,
  // Recovery loop modes
  output logic              holdover_en,
  output logic              limited_rate_en,
  // Pattern generator and checker
  output logic              pattern_gen_en,
  output logic              pattern_check_en,
  output logic              pattern_start
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [7:0] rec_ctl;
    logic [7:0] mode_ctl;
    logic [7:0] sel_ctl;
    logic [7:0] meas_ctl;
    logic       meas_start;
    logic       pat_start;
    logic [7:0] err_byte;
  } cdrtoc_state_t;

  cdrtoc_state_t state_r;
  cdrtoc_state_t state_nxt;

  // Byte of the 40-bit count; codes past the last byte read zero
  function automatic logic [7:0] cdrtoc_pick_byte(input logic [39:0] cnt,
                                                  input logic [2:0]  sel);
    logic [7:0] b;
    b = 8'h00;
    case (sel)
      3'h0:    b = cnt[7:0];
      3'h1:    b = cnt[15:8];
      3'h2:    b = cnt[23:16];
      3'h3:    b = cnt[31:24];
      3'h4:    b = cnt[39:32];
      default: b = 8'h00;
    endcase
    return b;
  endfunction

  // Length exponent of a code, base 18 stepping by 3
  function automatic logic [5:0] cdrtoc_len_log2(input logic [2:0] code);
    logic [5:0] p;
    // Largest code gives 18 + 21 = 39, so six bits never overflow
    p = 6'(6'(code) * cdrtoc_pkg::LEN_STEP_LOG2);
    return 6'(cdrtoc_pkg::LEN_BASE_LOG2 + p);
  endfunction

  logic wr_rec;
  logic wr_mode;
  logic wr_sel;
  logic wr_meas;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    wr_rec  = reg_wr_stb && (reg_addr == cdrtoc_pkg::OFS_RECOVERY_OUTPUT_CONTROL);
    wr_mode = reg_wr_stb && (reg_addr == cdrtoc_pkg::OFS_OUTPUT_MODE_CONTROL);
    wr_sel  = reg_wr_stb && (reg_addr == cdrtoc_pkg::OFS_RATE_HOLDOVER_SELECT);
    wr_meas = reg_wr_stb && (reg_addr == cdrtoc_pkg::OFS_ERROR_MEASURE_CONTROL);
    state_nxt = state_r;
    state_nxt.meas_start = 1'b0;
    state_nxt.pat_start  = 1'b0;
    if (wr_rec) begin
      state_nxt.rec_ctl = reg_wr_data;
      // Falling edge of the initiate bit launches generation
      state_nxt.pat_start = state_r.rec_ctl[cdrtoc_pkg::POS_PAT_INITIATE]
                            && !reg_wr_data[cdrtoc_pkg::POS_PAT_INITIATE];
    end
    if (wr_mode) begin
      state_nxt.mode_ctl = reg_wr_data;
    end
    if (wr_sel) begin
      state_nxt.sel_ctl = reg_wr_data;
    end
    if (wr_meas) begin
      state_nxt.meas_ctl = reg_wr_data;
      // A lone write of 0 does not start; the 1 must come first
      state_nxt.meas_start = state_r.meas_ctl[cdrtoc_pkg::POS_MEAS_START]
                             && !reg_wr_data[cdrtoc_pkg::POS_MEAS_START];
    end
    // Result byte is sampled every cycle so it tracks the count
    state_nxt.err_byte = cdrtoc_pick_byte(error_count,
                           state_r.meas_ctl[cdrtoc_pkg::POS_BYTE_SELECT +: 3]);
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      state_r.rec_ctl    <= cdrtoc_pkg::RST_RECOVERY_OUTPUT_CONTROL;
      state_r.mode_ctl   <= cdrtoc_pkg::RST_OUTPUT_MODE_CONTROL;
      state_r.sel_ctl    <= cdrtoc_pkg::RST_RATE_HOLDOVER_SELECT;
      state_r.meas_ctl   <= cdrtoc_pkg::RST_ERROR_MEASURE_CONTROL;
      state_r.meas_start <= 1'b0;
      state_r.pat_start  <= 1'b0;
      state_r.err_byte   <= 8'h00;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  logic [2:0] out_mode;
  logic [2:0] pat_mode;

  always_comb begin
    out_mode = state_r.mode_ctl[cdrtoc_pkg::POS_OUT_MODE +: 3];
    pat_mode = state_r.rec_ctl[cdrtoc_pkg::POS_PAT_MODE +: 3];
    odc_select      = 1'b0;
    ddr_mode        = 1'b0;
    pattern_path_en = 1'b0;
    // Reserved codes fall back to normal output rather than a guess
    case (out_mode)
      cdrtoc_pkg::OUT_NORMAL: begin
        odc_select = 1'b0;
      end
      cdrtoc_pkg::OUT_ODC: begin
        odc_select = 1'b1;
      end
      cdrtoc_pkg::OUT_DDR: begin
        ddr_mode = 1'b1;
      end
      cdrtoc_pkg::OUT_ODC_DDR: begin
        odc_select = 1'b1;
        ddr_mode   = 1'b1;
      end
      cdrtoc_pkg::OUT_PATTERN: begin
        pattern_path_en = 1'b1;
      end
      default: begin
        odc_select = 1'b0;
      end
    endcase
    pattern_gen_en   = (pat_mode == cdrtoc_pkg::PAT_GENERATE);
    pattern_check_en = (pat_mode == cdrtoc_pkg::PAT_CHECK);
  end

  assign data_buf_en       = !state_r.rec_ctl[cdrtoc_pkg::POS_DATA_BUF_OFF];
  assign clock_buf_en      = !state_r.rec_ctl[cdrtoc_pkg::POS_CLOCK_BUF_OFF];
  assign cdr_bypass        = state_r.rec_ctl[cdrtoc_pkg::POS_CDR_BYPASS];
  assign error_mon_en      = state_r.mode_ctl[cdrtoc_pkg::POS_MON_ENABLE];
  assign error_mon_standby = state_r.mode_ctl[cdrtoc_pkg::POS_MON_STANDBY];
  assign holdover_en       = state_r.sel_ctl[cdrtoc_pkg::POS_HOLDOVER];
  assign limited_rate_en   = state_r.sel_ctl[cdrtoc_pkg::POS_LIMITED_RATE];
  assign measure_start     = state_r.meas_start;
  assign pattern_start     = state_r.pat_start;
  assign error_byte        = state_r.err_byte;
  assign measure_len_log2  = cdrtoc_len_log2(
                               state_r.meas_ctl[cdrtoc_pkg::POS_MEAS_LENGTH +: 3]);

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  property p_data_buf_off;
    wr_rec |=> data_buf_en == !$past(reg_wr_data[6]);
  endproperty
  a_data_buf_off: assert property (p_data_buf_off)
    else $error("data buffer not off after disable write");

  property p_clock_buf;
    wr_rec |=> clock_buf_en == !$past(reg_wr_data[5]);
  endproperty
  a_clock_buf: assert property (p_clock_buf)
    else $error("clock buffer does not follow its disable bit");

  property p_mode_normal;
    wr_mode && reg_wr_data[2:0] == 3'h0 |=> !odc_select && !ddr_mode && !pattern_path_en;
  endproperty
  a_mode_normal: assert property (p_mode_normal)
    else $error("normal output mode not selected");

  property p_mode_odc;
    wr_mode && reg_wr_data[2:0] == 3'h1 |=> odc_select && !ddr_mode;
  endproperty
  a_mode_odc: assert property (p_mode_odc)
    else $error("offset circuit output mode not selected");

  property p_mode_ddr;
    wr_mode && reg_wr_data[2:0] == 3'h2 |=> ddr_mode && !odc_select;
  endproperty
  a_mode_ddr: assert property (p_mode_ddr)
    else $error("double data rate mode not selected");

  property p_mode_odc_ddr;
    wr_mode && reg_wr_data[2:0] == 3'h3 |=> ddr_mode && odc_select;
  endproperty
  a_mode_odc_ddr: assert property (p_mode_odc_ddr)
    else $error("offset circuit in double rate not selected");

  property p_holdover;
    wr_sel |=> holdover_en == $past(reg_wr_data[1]);
  endproperty
  a_holdover: assert property (p_holdover)
    else $error("holdover does not follow its bit");

  property p_limited;
    wr_sel |=> limited_rate_en == $past(reg_wr_data[3]);
  endproperty
  a_limited: assert property (p_limited)
    else $error("limited rate does not follow its bit");

  sequence s_meas_arm;
    wr_meas && reg_wr_data[3];
  endsequence
  sequence s_meas_clear;
    wr_meas && !reg_wr_data[3];
  endsequence
  sequence s_meas_pulse;
    measure_start ##1 !measure_start;
  endsequence
  property p_meas_start;
    s_meas_arm ##1 s_meas_clear |=> s_meas_pulse;
  endproperty
  a_meas_start: assert property (p_meas_start)
    else $error("measurement start pulse missing");

  // Other traffic may sit between the 1 and the 0
  property p_meas_start_gap;
    s_meas_arm ##1 (!wr_meas)[*3] ##1 s_meas_clear |=> s_meas_pulse;
  endproperty
  a_meas_start_gap: assert property (p_meas_start_gap)
    else $error("measurement start lost after a gap");

  property p_meas_lone;
    !measure_start ##1 (wr_meas && !reg_wr_data[3] && !state_r.meas_ctl[3])
      |=> !measure_start;
  endproperty
  a_meas_lone: assert property (p_meas_lone)
    else $error("measurement started without a prior one");

  property p_byte3;
    state_r.meas_ctl[2:0] == 3'h3 && !wr_meas |=> error_byte == $past(error_count[31:24]);
  endproperty
  a_byte3: assert property (p_byte3)
    else $error("error byte 3 not presented");

  property p_length;
    wr_meas |=> measure_len_log2 == 6'd18 + 6'd3 * 6'($past(reg_wr_data[7:5]));
  endproperty
  a_length: assert property (p_length)
    else $error("measurement length exponent wrong");

  property p_pat_start;
    wr_rec && reg_wr_data[3] ##1 (wr_rec && !reg_wr_data[3])
      |=> pattern_start ##1 !pattern_start;
  endproperty
  a_pat_start: assert property (p_pat_start)
    else $error("pattern initiate pulse wrong");

  property p_pat_mode;
    wr_rec |=> pattern_check_en == ($past(reg_wr_data[2:0]) == 3'h4)
               && pattern_gen_en == ($past(reg_wr_data[2:0]) == 3'h1);
  endproperty
  a_pat_mode: assert property (p_pat_mode)
    else $error("pattern mode decode wrong");

endmodule // cdrtoc_core
`default_nettype wire

// File: inc/cdrtoc_pkg.sv
/*
  Package of the clock recovery test and output control register bank:
  register offsets, field positions, reset values and mode codes.
  Assumes 8-bit registers written over the device's serial management port.
*/
`default_nettype none
package cdrtoc_pkg;
  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] OFS_RECOVERY_OUTPUT_CONTROL = 8'h1a;
  localparam logic [7:0] OFS_OUTPUT_MODE_CONTROL     = 8'h1b;
  localparam logic [7:0] OFS_RATE_HOLDOVER_SELECT    = 8'h1c;
  localparam logic [7:0] OFS_ERROR_MEASURE_CONTROL   = 8'h1e;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] RST_RECOVERY_OUTPUT_CONTROL = 8'h00;
  localparam logic [7:0] RST_OUTPUT_MODE_CONTROL     = 8'h00;
  localparam logic [7:0] RST_RATE_HOLDOVER_SELECT    = 8'h00;
  localparam logic [7:0] RST_ERROR_MEASURE_CONTROL   = 8'h00;

  // ****************************************
  // Field positions
  // ****************************************
  // recovery_output_control
  localparam int POS_CDR_BYPASS    = 7;
  localparam int POS_DATA_BUF_OFF  = 6;
  localparam int POS_CLOCK_BUF_OFF = 5;
  localparam int POS_PAT_INITIATE  = 3;
  localparam int POS_PAT_MODE      = 0;
  // output_mode_control
  localparam int POS_MON_ENABLE    = 5;
  localparam int POS_MON_STANDBY   = 4;
  localparam int POS_OUT_MODE      = 0;
  // rate_holdover_mode_select
  localparam int POS_LIMITED_RATE  = 3;
  localparam int POS_HOLDOVER      = 1;
  // error_measure_control
  localparam int POS_MEAS_LENGTH   = 5;
  localparam int POS_MEAS_START    = 3;
  localparam int POS_BYTE_SELECT   = 0;

  // ****************************************
  // Codes
  // ****************************************
  localparam logic [2:0] OUT_NORMAL   = 3'h0;
  localparam logic [2:0] OUT_ODC      = 3'h1;
  localparam logic [2:0] OUT_DDR      = 3'h2;
  localparam logic [2:0] OUT_ODC_DDR  = 3'h3;
  localparam logic [2:0] OUT_PATTERN  = 3'h5;
  localparam logic [2:0] PAT_OFF      = 3'h0;
  localparam logic [2:0] PAT_GENERATE = 3'h1;
  localparam logic [2:0] PAT_CHECK    = 3'h4;
  localparam logic [2:0] BYTE_LAST    = 3'h4;
  localparam logic [5:0] LEN_BASE_LOG2 = 6'h12;
  localparam logic [5:0] LEN_STEP_LOG2 = 6'h03;
endpackage
`default_nettype wire

// File: verification/cdr_test_and_output_control_tb.sv
/*
  Self-checking bench of the clock recovery test and output control bank.
  Assumes cdrtoc_pkg and cdrtoc_core are compiled before this file.
*/
`timescale 1ns/1ps
`default_nettype none
module cdr_test_and_output_control_tb;
  // ****************************************
  // Signals and model state
  // ****************************************
  localparam logic [7:0] A_R = cdrtoc_pkg::OFS_RECOVERY_OUTPUT_CONTROL;
  localparam logic [7:0] A_O = cdrtoc_pkg::OFS_OUTPUT_MODE_CONTROL;
  localparam logic [7:0] A_H = cdrtoc_pkg::OFS_RATE_HOLDOVER_SELECT;
  localparam logic [7:0] A_E = cdrtoc_pkg::OFS_ERROR_MEASURE_CONTROL;
  logic        clk_sys, resetn, reg_wr_stb;
  logic [7:0]  reg_addr, reg_wr_data, error_byte;
  logic [39:0] error_count;
  logic [5:0]  measure_len_log2;
  logic        data_buf_en, clock_buf_en, cdr_bypass, odc_select, ddr_mode;
  logic        pattern_path_en, error_mon_en, error_mon_standby, measure_start;
  logic        holdover_en, limited_rate_en, pattern_gen_en, pattern_check_en;
  logic        pattern_start;
  logic [7:0]  ro, om, hs, em, eb_e;
  logic        ms_e, ps_e;
  logic [31:0] rnd = 32'h2066;
  logic [31:0] r;
  int          fails = 0;
  int          n_compared = 0;

  cdrtoc_core i_cdrtoc_core (
    .clk_sys(clk_sys), .resetn(resetn), .reg_wr_stb(reg_wr_stb), .reg_addr(reg_addr),
    .reg_wr_data(reg_wr_data), .error_count(error_count), .data_buf_en(data_buf_en),
    .clock_buf_en(clock_buf_en), .cdr_bypass(cdr_bypass), .odc_select(odc_select),
    .ddr_mode(ddr_mode), .pattern_path_en(pattern_path_en), .error_mon_en(error_mon_en),
    .error_mon_standby(error_mon_standby), .measure_start(measure_start),
    .measure_len_log2(measure_len_log2), .error_byte(error_byte),
    .holdover_en(holdover_en), .limited_rate_en(limited_rate_en),
    .pattern_gen_en(pattern_gen_en), .pattern_check_en(pattern_check_en),
    .pattern_start(pattern_start));

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] xs();
    rnd ^= rnd << 13;
    rnd ^= rnd >> 17;
    rnd ^= rnd << 5;
    return rnd;
  endfunction

  task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic check_all();
    chk(data_buf_en, !ro[6]);
    chk(clock_buf_en, !ro[5]);
    chk(cdr_bypass, ro[7]);
    chk(pattern_path_en, om[2:0] == 3'h5);
    chk(odc_select, om[2:0] == 3'h1 || om[2:0] == 3'h3);
    chk(ddr_mode, om[2:0] == 3'h2 || om[2:0] == 3'h3);
    chk({error_mon_en, error_mon_standby}, om[5:4]);
    chk(holdover_en, hs[1]);
    chk(limited_rate_en, hs[3]);
    chk(measure_start, ms_e);
    chk(error_byte, eb_e);
    chk(measure_len_log2, 18 + 3 * em[7:5]);
    chk({pattern_gen_en, pattern_check_en}, {ro[2:0] == 3'h1, ro[2:0] == 3'h4});
    chk(pattern_start, ps_e);
  endtask

  // Model is advanced with the inputs that the next edge will take
  task automatic cycle(input logic stb, input logic [7:0] a, input logic [7:0] d);
    logic [2:0] s;
    s = em[2:0];
    error_count = 40'({xs(), xs()});
    eb_e = (s < 3'h5) ? error_count[8*s +: 8] : 8'h00;
    ms_e = stb && a == A_E && !d[3] && em[3];
    ps_e = stb && a == A_R && !d[3] && ro[3];
    if (stb && a == A_R) ro = d;
    if (stb && a == A_O) om = d;
    if (stb && a == A_H) hs = d;
    if (stb && a == A_E) em = d;
    reg_wr_stb = stb;
    reg_addr = a;
    reg_wr_data = d;
    @(posedge clk_sys);
    #2;
    check_all();
  endtask

  task automatic do_reset();
    resetn = 1'b0;
    reg_wr_stb = 1'b0;
    reg_addr = 8'h00;
    reg_wr_data = 8'h00;
    error_count = 40'h00;
    {ro, om, hs, em, eb_e, ms_e, ps_e} = '0;
    repeat (12) @(posedge clk_sys);
    #2;
    resetn = 1'b1;
    check_all();
  endtask

  task automatic tally_and_finish();
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // ****************************************
  // Clock, watchdog and tests
  // ****************************************
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // Whole run needs about 3100 cycles; allow generous margin
  initial begin
    #(40 * 20000);
    fails++;
    $display("unexpected at %0t: watchdog expired", $time);
    tally_and_finish();
  end

  initial begin
    do_reset();
    $display("test reset values done");
    // Repeated ones, zero without a one, back-to-back one then zero
    cycle(1'b1, A_E, 8'h00);
    cycle(1'b1, A_E, 8'h08);
    cycle(1'b1, A_E, 8'h08);
    cycle(1'b1, A_E, 8'h00);
    cycle(1'b1, A_E, 8'h00);
    cycle(1'b1, A_R, 8'h08);
    cycle(1'b0, A_R, 8'h00);
    cycle(1'b1, A_R, 8'h01);
    // Start with unrelated writes between the 1 and the 0
    cycle(1'b1, A_E, 8'h08);
    repeat (3) cycle(1'b1, A_H, 8'h00);
    cycle(1'b1, A_E, 8'h00);
    $display("test start pulses done");
    for (int i = 0; i < 8; i++) begin
      cycle(1'b1, A_O, 8'(i));
      cycle(1'b1, A_E, 8'(i * 33));
      cycle(1'b1, A_R, 8'(i * 32 + i));
      cycle(1'b1, A_H, 8'(i * 2));
      cycle(1'b1, 8'h1d, 8'hff);
    end
    $display("test code tables done");
    // Random traffic, unmapped addresses and a reset in mid-run
    for (int i = 0; i < 3000; i++) begin
      r = xs();
      if (i == 1500) do_reset();
      case (r[4:2])
        3'h0: cycle(r[0] | r[1], A_R, r[15:8]);
        3'h1: cycle(r[0] | r[1], A_O, r[15:8]);
        3'h2: cycle(r[0] | r[1], A_H, r[15:8]);
        3'h3, 3'h4: cycle(r[0] | r[1], A_E, r[15:8]);
        default: cycle(r[0] | r[1], r[23:16], r[15:8]);
      endcase
    end
    $display("test random traffic done");
    tally_and_finish();
  end
endmodule // cdr_test_and_output_control_tb
`default_nettype wire
